// file: vcc_regs.sv
// virtual channel extended capability registers of a root port
// assumes config requests come from logic on clk, one request per cycle at most
module vcc_regs
	import vcc_pkg::*;
(
	input  wire logic                  clk,           // 50 MHz system clock
	input  wire logic                  rst,           // synchronous, active high
	input  wire logic                  cfg_rd,        // read request strobe
	input  wire logic                  cfg_wr,        // write request strobe
	input  wire logic [VCC_ADDR_W-1:0] cfg_addr,      // byte address, dword aligned
	input  wire logic [VCC_DATA_W-1:0] cfg_wdata,     // write data
	input  wire logic [3:0]            cfg_be,        // write byte enables
	output logic                       cfg_ack_r,     // one-cycle answer pulse
	output logic [VCC_DATA_W-1:0]      cfg_rdata_r,   // read data, zero on writes without a read
	output logic [2:0]                 arb_select_r   // stored arbitration select
);

	// dword match; low two address bits are ignored
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction : hit

	// assembled read-only words
	logic [31:0] header_w;     // capability header
	logic [31:0] cap_one_w;    // port capability one
	logic [31:0] cap_two_w;    // port capability two
	logic [31:0] control_w;    // control, zero-extended
	logic [31:0] rdata_nxt;    // read mux result

	// header is pure wiring of constant fields
	assign header_w = {VCC_NEXT_CAPABILITY_POINTER,   // see (R2)
	                   VCC_CAPABILITY_VERSION,        // see (R3)
	                   VCC_EXTENDED_CAPABILITY_ID};   // see (R4)

	// counts are zero: no channel beyond the default one
	assign cap_one_w = {25'h0000000, VCC_LOW_PRIORITY_EXTRA_COUNT, // see (R7)
	                    1'h0, VCC_EXTRA_CHANNEL_COUNT};            // see (R6)

	// no table since priority is fixed
	assign cap_two_w = {VCC_ARBITRATION_TABLE_OFFSET, 24'h000000}; // see (R9)

	// reserved control bits tie to zero; upper half is outside the register
	assign control_w = {16'h0000, 12'h000, arb_select_r, 1'h0};    // see (R10) see (R12)

	// read mux; unmapped offsets answer zero
	always_comb begin
		if (hit(cfg_addr, VCC_OFS_HEADER)) begin
			rdata_nxt = header_w;                 // see (R1)
		end else if (hit(cfg_addr, VCC_OFS_CAP_ONE)) begin
			rdata_nxt = cap_one_w;                // see (R5)
		end else if (hit(cfg_addr, VCC_OFS_CAP_TWO)) begin
			rdata_nxt = cap_two_w;                // see (R8)
		end else if (hit(cfg_addr, VCC_OFS_CONTROL)) begin
			rdata_nxt = control_w;
		end else begin
			rdata_nxt = 32'h00000000;
		end
	end

	// arbitration select: only lane 0 carries it, other writes fall away
	// value is kept for software only; nothing downstream arbitrates on it
	always_ff @(posedge clk) begin
		if (rst) begin
			arb_select_r <= VCC_SEL_RESET;        // see (R11)
		end else if (cfg_wr && cfg_be[0] && hit(cfg_addr, VCC_OFS_CONTROL)) begin
			arb_select_r <= cfg_wdata[VCC_SEL_MSB:VCC_SEL_LSB]; // see (R11) see (R13)
		end
	end

	// answer one cycle after any request; a write without a read answers with zero data
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_ack_r   <= 1'b0;
			cfg_rdata_r <= 32'h00000000;
		end else begin
			cfg_ack_r   <= cfg_rd | cfg_wr;
			cfg_rdata_r <= cfg_rd ? rdata_nxt : 32'h00000000; // see (R12)
		end
	end

	// all checks below live on clk; reset masks them unless they say otherwise
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// helper decodes; the read ones registered so a check lines up with the answer cycle, wr_sel left combinational
	logic rd_hdr_r;    // header read taken last cycle
	logic rd_one_r;    // capability one read taken last cycle
	logic rd_two_r;    // capability two read taken last cycle
	logic rd_ctl_r;    // control read taken last cycle
	logic rd_none_r;   // unmapped read taken last cycle
	logic wr_sel;      // write that reaches the select field this cycle

	// a write only lands with lane 0 enabled at the control dword
	assign wr_sel = cfg_wr && cfg_be[0] && hit(cfg_addr, VCC_OFS_CONTROL);

	// header read tracker
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_hdr_r <= 1'b0;
		end else begin
			rd_hdr_r <= cfg_rd && hit(cfg_addr, VCC_OFS_HEADER);
		end
	end

	// capability one read tracker
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_one_r <= 1'b0;
		end else begin
			rd_one_r <= cfg_rd && hit(cfg_addr, VCC_OFS_CAP_ONE);
		end
	end

	// capability two read tracker
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_two_r <= 1'b0;
		end else begin
			rd_two_r <= cfg_rd && hit(cfg_addr, VCC_OFS_CAP_TWO);
		end
	end

	// control read tracker
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ctl_r <= 1'b0;
		end else begin
			rd_ctl_r <= cfg_rd && hit(cfg_addr, VCC_OFS_CONTROL);
		end
	end

	// unmapped read tracker; anything outside the four dwords
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_none_r <= 1'b0;
		end else begin
			rd_none_r <= cfg_rd && !hit(cfg_addr, VCC_OFS_HEADER)
			             && !hit(cfg_addr, VCC_OFS_CAP_ONE)
			             && !hit(cfg_addr, VCC_OFS_CAP_TWO)
			             && !hit(cfg_addr, VCC_OFS_CONTROL);
		end
	end

	// whole header word, answered with the pulse
	// expected value written out, not taken from the package
	a_header_whole: assert property (rd_hdr_r |-> cfg_ack_r && cfg_rdata_r == 32'h14010002) // see (R1)
		else $error("header read value wrong");

	// next pointer field names the link declaration entry
	// checked from the request side, one cycle ahead
	a_next_pointer: assert property (cfg_rd && hit(cfg_addr, VCC_OFS_HEADER) |=> // see (R2)
		cfg_rdata_r[31:20] == 12'h140)
		else $error("next pointer wrong");

	// version stays at 1 whatever generation the port runs
	a_version_fixed: assert property (rd_hdr_r |-> cfg_rdata_r[19:16] == 4'h1) // see (R3)
		else $error("capability version wrong");

	// identifier marks the chained entry as channel capability
	a_cap_identifier: assert property (rd_hdr_r |-> cfg_rdata_r[15:0] == 16'h0002) // see (R4)
		else $error("capability identifier wrong");

	// capability one reads all zeros, with the pulse
	a_cap_one_zero: assert property (rd_one_r |-> cfg_ack_r && cfg_rdata_r == 32'h0) // see (R5)
		else $error("capability one not zero");

	// only the default channel exists
	a_extra_count: assert property (rd_one_r |-> cfg_rdata_r[2:0] == 3'h0) // see (R6)
		else $error("extra channel count not zero");

	// zero low priority extras means strict arbitration
	a_low_prio_count: assert property (rd_one_r |-> cfg_rdata_r[6:4] == 3'h0) // see (R7)
		else $error("low priority count not zero");

	// reserved bits of capability one stay clear
	a_one_reserved: assert property (rd_one_r |-> cfg_rdata_r[31:7] == 25'h0 // see (R12)
		&& cfg_rdata_r[3] == 1'b0)
		else $error("capability one reserved bits set");

	// capability two reads all zeros
	a_cap_two_zero: assert property (rd_two_r |-> cfg_rdata_r == 32'h0) // see (R8)
		else $error("capability two not zero");

	// no arbitration table because channel priority is fixed
	a_table_offset: assert property (rd_two_r |-> cfg_rdata_r[31:24] == 8'h00) // see (R9)
		else $error("table offset not zero");

	// reserved low bits of capability two stay clear
	a_two_reserved: assert property (rd_two_r |-> cfg_rdata_r[23:0] == 24'h0) // see (R12)
		else $error("capability two reserved bits set");

	// control reads back the select as it stood when the read was taken
	a_ctl_readback: assert property (rd_ctl_r |-> // see (R10)
		cfg_rdata_r == {28'h0, $past(arb_select_r), 1'b0})
		else $error("control readback wrong");

	// register is only 16 bits; the upper half of the dword is empty
	a_ctl_upper_zero: assert property (rd_ctl_r |-> cfg_rdata_r[31:16] == 16'h0) // see (R10)
		else $error("control upper half set");

	// reserved control bits around the select never show
	a_ctl_reserved: assert property (rd_ctl_r |-> cfg_rdata_r[15:4] == 12'h0 // see (R12)
		&& cfg_rdata_r[0] == 1'b0)
		else $error("control reserved bits set");

	// a lane 0 control write stores bits 3:1 at the next edge
	a_select_store: assert property (wr_sel |=> arb_select_r == $past(cfg_wdata[3:1])) // see (R11)
		else $error("arbitration select not stored");

	// without such a write the stored select never moves
	a_select_hold: assert property (!wr_sel |=> $stable(arb_select_r)) // see (R13)
		else $error("arbitration select changed without write");

	// lane 0 off: the write falls away
	a_select_no_lane: assert property (cfg_wr && !cfg_be[0] |=> $stable(arb_select_r)) // see (R12)
		else $error("select changed without lane 0");

	// reset clears the select; reset itself must not mask this one
	a_select_reset: assert property (@(posedge clk) disable iff (1'b0) // see (R11)
		rst |=> arb_select_r == 3'h0)
		else $error("select not cleared by reset");

	// reset leaves no answer and no data behind
	a_ack_reset: assert property (@(posedge clk) disable iff (1'b0) // see (R10)
		rst |=> !cfg_ack_r && cfg_rdata_r == 32'h0)
		else $error("answer outputs not cleared by reset");

	// every taken request answers exactly one cycle later
	a_ack_follows: assert property ((cfg_rd || cfg_wr) |=> cfg_ack_r) // see (R12)
		else $error("answer pulse missing");

	// and no answer appears without a request
	a_ack_idle: assert property (!(cfg_rd || cfg_wr) |=> !cfg_ack_r) // see (R12)
		else $error("answer pulse without request");

	// a plain write answers with zero data
	a_write_no_data: assert property (cfg_wr && !cfg_rd |=> cfg_rdata_r == 32'h0) // see (R12)
		else $error("write answered with data");

	// unmapped offsets read as zero
	a_unmapped_zero: assert property (rd_none_r |-> cfg_rdata_r == 32'h0) // see (R12)
		else $error("unmapped read returned data");

	// data bus rests at zero between answers
	a_idle_no_data: assert property (!cfg_ack_r |-> cfg_rdata_r == 32'h0) // see (R12)
		else $error("read data outside answer");

	// read and write together: the read sees the select before the write
	a_rd_wr_old: assert property (cfg_rd && wr_sel |=> // see (R11)
		cfg_rdata_r[3:1] == $past(arb_select_r))
		else $error("simultaneous read saw new select");

endmodule : vcc_regs

// file: vcc_pkg.sv
// constants for the virtual channel capability register block
// assumes a single 50 MHz clock and a synchronous active-high reset
// Function
// (R1) header at 0x100 reads 0x14010002
// (R2) header bits 31:20 hold next pointer 0x140
// (R3) header bits 19:16 hardwired version 1
// (R4) header bits 15:0 read identifier 0x0002
// (R5) capability word one at 0x104 reads zero
// (R6) extra channel count bits 2:0 zero
// (R7) low priority extra count bits 6:4 zero
// (R8) capability word two at 0x108 reads zero
// (R9) arbitration table offset bits 31:24 zero
// (R10) port control 16 bits at 0x10C, resets zero
// (R11) arbitration select bits 3:1 writable, resets zero
// (R12) read-only writes ignored, reserved bits read zero
// (R13) arbitration select stored, no behavioural effect
package vcc_pkg;

	// configuration access geometry
	localparam int unsigned VCC_ADDR_W = 12;                  // extended config space
	localparam int unsigned VCC_DATA_W = 32;                  // one dword per access

	// register byte offsets
	localparam logic [11:0] VCC_OFS_HEADER  = 12'h100;        // capability header
	localparam logic [11:0] VCC_OFS_CAP_ONE = 12'h104;        // port capability word one
	localparam logic [11:0] VCC_OFS_CAP_TWO = 12'h108;        // port capability word two
	localparam logic [11:0] VCC_OFS_CONTROL = 12'h10C;        // port control

	// header fields
	localparam logic [11:0] VCC_NEXT_CAPABILITY_POINTER = 12'h140;   // link declaration next
	localparam logic [3:0]  VCC_CAPABILITY_VERSION      = 4'h1;      // kept for newer gen
	localparam logic [15:0] VCC_EXTENDED_CAPABILITY_ID  = 16'h0002;  // channel capability
	localparam logic [31:0] VCC_HEADER_RESET            = 32'h14010002;

	// capability word fields, all zero: default channel only
	localparam logic [2:0]  VCC_EXTRA_CHANNEL_COUNT        = 3'h0;
	localparam logic [2:0]  VCC_LOW_PRIORITY_EXTRA_COUNT   = 3'h0;
	localparam logic [7:0]  VCC_ARBITRATION_TABLE_OFFSET   = 8'h00;
	localparam logic [31:0] VCC_CAP_ONE_RESET              = 32'h00000000;
	localparam logic [31:0] VCC_CAP_TWO_RESET              = 32'h00000000;

	// control word layout
	localparam int unsigned VCC_CTL_W       = 16;             // control register width
	localparam int unsigned VCC_SEL_LSB     = 1;              // arbitration select low bit
	localparam int unsigned VCC_SEL_MSB     = 3;              // arbitration select high bit
	localparam logic [15:0] VCC_CTL_RESET   = 16'h0000;
	localparam logic [2:0]  VCC_SEL_RESET   = 3'h0;

endpackage : vcc_pkg

// file: vcc_regs_tb.sv
// self-checking bench for the channel capability register block
// assumes vcc_regs answers each request exactly one cycle after it is taken
module vcc_regs_tb;
	import vcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;      // 50 MHz system clock
	logic        rst = 1'b1;      // synchronous reset
	logic        cfg_rd = 1'b0;   // read strobe
	logic        cfg_wr = 1'b0;   // write strobe
	logic [11:0] cfg_addr = 12'h000;
	logic [31:0] cfg_wdata = 32'h00000000;
	logic [3:0]  cfg_be = 4'h0;
	logic        cfg_ack_r;       // answer pulse
	logic [31:0] cfg_rdata_r;     // read data
	logic [2:0]  arb_select_r;    // stored select
	logic [31:0] q;               // answer data of the last access, read or write
	int          miscompares = 0;
	int          comparisons = 0;

	// free-running clock, 20 ns period
	always #10 clk = ~clk;

	vcc_regs dut_u (.clk(clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_ack_r(cfg_ack_r), .cfg_rdata_r(cfg_rdata_r),
		.arb_select_r(arb_select_r));

	// one comparison, four-state exact
	task check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	// single place where the run ends
	task wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up

	// one request; latency is fixed at one cycle, so no open wait is needed
	task access(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		cfg_rd <= !wr;
		cfg_wr <= wr;
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_be <= be;
		@(posedge clk);
		cfg_rd <= 1'b0;
		cfg_wr <= 1'b0;
		#1;
		if (cfg_ack_r !== 1'b1) begin
			miscompares++;
			wrap_up;
		end else begin
			q = cfg_rdata_r;
		end
	endtask : access

	// read a register and compare with its documented value
	task rd(input logic [11:0] a, input logic [31:0] want);
		access(1'b0, a, 32'h00000000, 4'h0);
		check(q, want);
	endtask : rd

	// reset values of every register in the block
	task reset_values;
		rd(12'h100, 32'h14010002);
		check({20'h00000, q[31:20]}, 32'h00000140);
		check({28'h0000000, q[19:16]}, 32'h00000001);
		check({16'h0000, q[15:0]}, 32'h00000002);
		rd(12'h104, 32'h00000000);
		check({25'h0000000, q[6:4], 1'b0, q[2:0]}, 32'h00000000);
		rd(12'h108, 32'h00000000);
		check({24'h000000, q[31:24]}, 32'h00000000);
		rd(12'h10C, 32'h00000000);
		check({29'h00000000, arb_select_r}, 32'h00000000);
	endtask : reset_values

	// all-ones writes to read-only words must leave them untouched
	task ro_writes;
		access(1'b1, 12'h100, 32'hFFFFFFFF, 4'hF);
		check(q, 32'h00000000);
		access(1'b1, 12'h104, 32'hFFFFFFFF, 4'hF);
		access(1'b1, 12'h108, 32'hFFFFFFFF, 4'hF);
		rd(12'h100, 32'h14010002);
		rd(12'h104, 32'h00000000);
		rd(12'h108, 32'h00000000);
	endtask : ro_writes

	// select field stores, reserved control bits stay zero, then reset clears it
	task select_field;
		access(1'b1, 12'h10C, 32'hFFFFFFFF, 4'h1);
		check({29'h00000000, arb_select_r}, 32'h00000007);
		rd(12'h10C, 32'h0000000E);
		access(1'b1, 12'h10C, 32'h00000004, 4'h0);
		rd(12'h10C, 32'h0000000E);
		access(1'b1, 12'h10C, 32'h00000004, 4'h1);
		rd(12'h10C, 32'h00000004);
		// read and write in one cycle: data is the value before the write
		@(posedge clk);
		cfg_rd <= 1'b1;
		cfg_wr <= 1'b1;
		cfg_addr <= 12'h10C;
		cfg_wdata <= 32'h0000000A;
		cfg_be <= 4'h1;
		@(posedge clk);
		cfg_rd <= 1'b0;
		cfg_wr <= 1'b0;
		#1;
		check({31'h00000000, cfg_ack_r}, 32'h00000001);
		check(cfg_rdata_r, 32'h00000004);
		check({29'h00000000, arb_select_r}, 32'h00000005);
		rd(12'h200, 32'h00000000);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rd(12'h10C, 32'h00000000);
	endtask : select_field

	// main sequence: 4-cycle reset, then the scenarios
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		reset_values;
		ro_writes;
		select_field;
		wrap_up;
	end

endmodule : vcc_regs_tb
